// file: include/cpu_bus_pkg.sv
// constants, types and register map of the local bus pin front end
// Summary of operation
// - dma requests active high, level, synchronised
// - non-maskable input taken as vector type two
// - nmi rise latched, served at instruction boundary
// - nothing in software masks the nmi
// - maskable request inputs active high, synchronised
// - pins two and three may be ack outputs
// - each maskable input edge or level selectable
// - first state drives upper four address bits
// - later states top status shows cycle origin
// - later states lower three status pins low
// - middle address byte valid whole cycle
// - low byte address first, then data
// - address and data pins float in hold/reset
// - compatible mode keeps refresh indicator high
// - enhanced mode drives refresh low on refresh
// - refresh indicator floats in hold or reset
// - enhanced only if strap high then low later
package cpu_bus_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFS_CONFIG    = 8'h00; // edge select and ack mode
  localparam logic [7:0] OFS_BUS_ADDR  = 8'h04; // 20-bit cycle address
  localparam logic [7:0] OFS_BUS_WDATA = 8'h08; // byte to write
  localparam logic [7:0] OFS_BUS_CMD   = 8'h0c; // start and cycle kind
  localparam logic [7:0] OFS_STATUS    = 8'h10; // live pin and block state
  localparam logic [7:0] OFS_BUS_RDATA = 8'h14; // byte read by last cycle
  localparam logic [7:0] OFS_INT_ACK   = 8'h18; // acknowledge interrupts

  // bus command field positions
  localparam int CMD_START   = 0;
  localparam int CMD_WRITE   = 1;
  localparam int CMD_DMA     = 2;
  localparam int CMD_REFRESH = 3;

  // config field positions
  localparam int CFG_EDGE_LSB = 0; // four edge-select bits
  localparam int CFG_ACK_LSB  = 4; // two ack-mode bits

  // reset values of software state
  localparam logic [3:0] EDGE_SEL_RST = 4'h0; // all level sensitive
  localparam logic [1:0] ACK_MODE_RST = 2'h0; // all pins are requests

  // vector type raised by the non-maskable input
  localparam logic [7:0] NMI_VECTOR_TYPE = 8'h02;

  // processor clock output is pclk divided by this
  localparam int PROCESSOR_CLOCK_OUTPUT_DIV = 2;
  // strap is checked again this many clock output periods after release
  localparam int STRAP_DELAY_PROCESSOR_CLOCK_OUTPUT = 4;
  localparam int STRAP_DELAY_PCLK   = STRAP_DELAY_PROCESSOR_CLOCK_OUTPUT * PROCESSOR_CLOCK_OUTPUT_DIV;
  localparam logic [3:0] STRAP_CNT_LAST = 4'(STRAP_DELAY_PCLK - 1);

  // bus states of one local bus cycle
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_T1   = 3'b001,
    ST_T2   = 3'b010,
    ST_T3   = 3'b011,
    ST_TW   = 3'b100,
    ST_T4   = 3'b101
  } bus_state_t;

  // bus pin group driven by the block
  typedef struct packed {
    logic [3:0] addr_status;  // upper address / status pins
    logic [7:0] addr_mid;     // dedicated middle address byte
    logic [7:0] ad_out;       // multiplexed low byte, output value
    logic       addr_oe_n;    // enable of upper and middle pins, low drives
    logic       ad_oe_n;      // enable of multiplexed pins, low drives
    logic       refresh;      // refresh indicator value
    logic       refresh_oe_n; // enable of refresh indicator, low drives
  } bus_pins_t;

  localparam bus_pins_t PINS_RST = '{4'h0, 8'h00, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage : cpu_bus_pkg

// file: hw/cpu_bus_pin_front_end.sv
// pin front end of the local bus, request inputs and apb control port
module cpu_bus_pin_front_end (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // local bus pins
  output logic                       processor_clock_output,
  output cpu_bus_pkg::bus_pins_t     bus_pins,
  input  wire logic [7:0]            multiplexed_addr_data_low_byte_in,
  input  wire logic                  bus_ready,
  input  wire logic                  hold_request,
  output logic                       hold_granted,
  input  wire logic                  mode_strap,
  // request inputs
  input  wire logic                  dma_request_channel_zero,
  input  wire logic                  dma_request_channel_one,
  input  wire logic                  nmi_input,
  input  wire logic                  interrupt_request_zero,
  input  wire logic                  interrupt_request_one,
  input  wire logic                  interrupt_request_two_or_ack_zero_in,
  output logic                       interrupt_request_two_or_ack_zero_out,
  output logic                       interrupt_request_two_or_ack_zero_oe_n,
  input  wire logic                  interrupt_request_three_or_ack_one_in,
  output logic                       interrupt_request_three_or_ack_one_out,
  output logic                       interrupt_request_three_or_ack_one_oe_n,
  // towards the processor core
  input  wire logic                  instruction_boundary,
  output logic [1:0]                 dma_request_sync,
  output logic [3:0]                 interrupt_pending,
  output logic                       nmi_take,
  output logic [7:0]                 nmi_vector,
  output logic                       enhanced_mode
);
  import cpu_bus_pkg::*;

  // whole state of the block
  typedef struct packed {
    logic        clk_div;     // processor clock output level
    bus_state_t  bus_st;      // current bus state
    logic [19:0] addr;        // address of the cycle
    logic [7:0]  wdata;       // byte to write
    logic        cmd_write;   // cycle writes
    logic        cmd_dma;     // cycle started for dma
    logic        cmd_refresh; // cycle is a refresh
    logic        start_pend;  // cycle waits for the next tick
    logic [7:0]  rdata;       // byte captured in fourth state
    logic        hold_gnt;    // bus handed over
    logic [3:0]  edge_sel;    // 1 edge, 0 level per input
    logic [1:0]  ack_mode;    // pins two and three as ack outputs
    logic [1:0]  dma_s1;      // dma synchroniser first stage
    logic [1:0]  dma_s2;      // dma synchroniser second stage
    logic [3:0]  int_s1;      // interrupt synchroniser first stage
    logic [3:0]  int_s2;      // interrupt synchroniser second stage
    logic [3:0]  int_d;       // delayed copy for edge detection
    logic [3:0]  int_pend;    // pending maskable requests
    logic [1:0]  ack_n;       // ack output levels, active low
    logic        nmi_s1;      // nmi synchroniser first stage
    logic        nmi_s2;      // nmi synchroniser second stage
    logic        nmi_d;       // delayed copy for edge detection
    logic        nmi_pend;    // latched nmi rise
    logic        nmi_take;    // one-cycle service pulse
    logic        strap_first; // strap level at reset release
    logic [3:0]  strap_cnt;   // cycles since release
    logic        strap_done;  // mode has been decided
    logic        enhanced;    // enhanced mode selected
    logic [31:0] prdata;      // apb read data
    logic        perr;        // apb error for the access phase
    bus_pins_t   pins;        // registered pin group
  } state_t;

  // reset state: ack outputs idle high, pins floated, the rest zero
  localparam state_t STATE_RST = '{bus_st: ST_IDLE, edge_sel: EDGE_SEL_RST, ack_mode: ACK_MODE_RST,
                                   ack_n: 2'h3, pins: PINS_RST, default: '0};

  // true for a known register offset
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == OFS_CONFIG) || (a == OFS_BUS_ADDR) || (a == OFS_BUS_WDATA) ||
                  (a == OFS_BUS_CMD) || (a == OFS_STATUS) || (a == OFS_BUS_RDATA) ||
                  (a == OFS_INT_ACK);
  endfunction : addr_mapped

  // true while a cycle occupies the bus (first to fourth state)
  function automatic logic in_cycle(input bus_state_t s);
    in_cycle = (s != ST_IDLE);
  endfunction : in_cycle

  state_t s_r;   // registered state
  state_t s_nxt; // next state

  logic       tick;     // one pclk per clock output period
  logic       wr_acc;   // apb write in its access phase
  logic       rd_setup; // apb read in its setup phase
  logic       busy;     // bus cycle running or queued
  logic [3:0] int_raw;  // request pin levels
  logic [3:0] int_rise; // synchronised rising edges
  logic [3:0] ack_wr;   // acknowledge bits written this cycle

  // next-state logic of the whole block
  always_comb begin
    s_nxt    = s_r;
    tick     = s_r.clk_div;
    wr_acc   = psel && penable && pwrite;
    rd_setup = psel && !penable && !pwrite;
    busy     = in_cycle(s_r.bus_st) || s_r.start_pend;
    int_raw  = {interrupt_request_three_or_ack_one_in, interrupt_request_two_or_ack_zero_in,
                interrupt_request_one, interrupt_request_zero};
    int_rise = s_r.int_s2 & ~s_r.int_d;
    ack_wr   = (wr_acc && paddr == OFS_INT_ACK) ? pwdata[3:0] : 4'h0;

    // clock output divider
    s_nxt.clk_div = ~s_r.clk_div;

    // mode strap: first level at release, second after the delay
    if (!s_r.strap_done) begin
      if (s_r.strap_cnt == 4'h0) begin
        s_nxt.strap_first = mode_strap;
      end
      if (s_r.strap_cnt == STRAP_CNT_LAST) begin
        s_nxt.enhanced   = s_r.strap_first && !mode_strap;
        s_nxt.strap_done = 1'b1;
      end else begin
        s_nxt.strap_cnt = s_r.strap_cnt + 4'h1;
      end
    end

    // dma request synchronisers
    s_nxt.dma_s1 = {dma_request_channel_one, dma_request_channel_zero};
    s_nxt.dma_s2 = s_r.dma_s1;

    // maskable request synchronisers and pending flags
    s_nxt.int_s1 = int_raw;
    s_nxt.int_s2 = s_r.int_s1;
    s_nxt.int_d  = s_r.int_s2;
    for (int i = 0; i < 4; i++) begin
      if ((i == 2 && s_r.ack_mode[0]) || (i == 3 && s_r.ack_mode[1])) begin
        // pin works as an ack output, no request from it
        s_nxt.int_pend[i] = 1'b0;
      end else if (s_r.edge_sel[i]) begin
        // edge: latched rise, a new rise beats a clear
        s_nxt.int_pend[i] = int_rise[i] || (s_r.int_pend[i] && !ack_wr[i]);
      end else begin
        // level: follows the synchronised pin
        s_nxt.int_pend[i] = s_r.int_s2[i];
      end
    end

    // acknowledge pulses on pins two and three in ack mode
    for (int j = 0; j < 2; j++) begin
      s_nxt.ack_n[j] = !(s_r.ack_mode[j] && ack_wr[j+2]);
    end

    // nmi: synchronise, latch rise, serve at instruction boundary; no mask exists
    s_nxt.nmi_s1   = nmi_input;
    s_nxt.nmi_s2   = s_r.nmi_s1;
    s_nxt.nmi_d    = s_r.nmi_s2;
    s_nxt.nmi_take = instruction_boundary && s_r.nmi_pend;
    if (s_r.nmi_s2 && !s_r.nmi_d) begin
      s_nxt.nmi_pend = 1'b1;
    end else if (s_nxt.nmi_take) begin
      s_nxt.nmi_pend = 1'b0;
    end

    // apb writes
    if (wr_acc) begin
      case (paddr)
        OFS_CONFIG: begin
          s_nxt.edge_sel = pwdata[CFG_EDGE_LSB +: 4];
          s_nxt.ack_mode = pwdata[CFG_ACK_LSB +: 2];
        end
        OFS_BUS_ADDR: begin
          if (!busy) s_nxt.addr = pwdata[19:0];
        end
        OFS_BUS_WDATA: begin
          if (!busy) s_nxt.wdata = pwdata[7:0];
        end
        OFS_BUS_CMD: begin
          // a start while busy is ignored
          if (!busy && pwdata[CMD_START]) begin
            s_nxt.start_pend  = 1'b1;
            s_nxt.cmd_write   = pwdata[CMD_WRITE];
            s_nxt.cmd_dma     = pwdata[CMD_DMA];
            s_nxt.cmd_refresh = pwdata[CMD_REFRESH];
          end
        end
        default: begin
        end
      endcase
    end

    // bus state sequencer, one step per clock output period
    if (tick) begin
      case (s_r.bus_st)
        ST_IDLE: begin
          if (s_r.hold_gnt) begin
            s_nxt.hold_gnt = hold_request;
          end else if (hold_request) begin
            s_nxt.hold_gnt = 1'b1; // hold wins over a queued cycle
          end else if (s_r.start_pend) begin
            s_nxt.bus_st     = ST_T1;
            s_nxt.start_pend = 1'b0;
          end
        end
        ST_T1:   s_nxt.bus_st = ST_T2;
        ST_T2:   s_nxt.bus_st = ST_T3;
        ST_T3:   s_nxt.bus_st = bus_ready ? ST_T4 : ST_TW;
        ST_TW:   s_nxt.bus_st = bus_ready ? ST_T4 : ST_TW;
        ST_T4: begin
          if (!s_r.cmd_write) s_nxt.rdata = multiplexed_addr_data_low_byte_in;
          s_nxt.bus_st = ST_IDLE;
        end
        default: s_nxt.bus_st = ST_IDLE;
      endcase
    end

    // apb read data prepared in the setup phase
    if (psel && !penable) begin
      s_nxt.perr = !addr_mapped(paddr);
    end
    if (rd_setup) begin
      case (paddr)
        OFS_CONFIG:    s_nxt.prdata = {26'h0, s_r.ack_mode, s_r.edge_sel};
        OFS_BUS_ADDR:  s_nxt.prdata = {12'h000, s_r.addr};
        OFS_BUS_WDATA: s_nxt.prdata = {24'h000000, s_r.wdata};
        OFS_BUS_CMD:   s_nxt.prdata = {28'h0, s_r.cmd_refresh, s_r.cmd_dma, s_r.cmd_write, busy};
        OFS_STATUS:    s_nxt.prdata = {19'h0, s_r.bus_st, s_r.hold_gnt, busy, s_r.enhanced,
                                       s_r.nmi_pend, s_r.int_pend, s_r.dma_s2};
        OFS_BUS_RDATA: s_nxt.prdata = {24'h000000, s_r.rdata};
        default:       s_nxt.prdata = 32'h00000000;
      endcase
    end

    // pin group from the next state so pins change with the state
    s_nxt.pins.addr_oe_n    = s_nxt.hold_gnt;
    s_nxt.pins.refresh_oe_n = s_nxt.hold_gnt;
    s_nxt.pins.addr_mid     = s_nxt.addr[15:8];
    if (s_nxt.bus_st == ST_T1 || s_nxt.bus_st == ST_IDLE) begin
      s_nxt.pins.addr_status = s_nxt.addr[19:16];
      s_nxt.pins.ad_out      = s_nxt.addr[7:0];
      s_nxt.pins.ad_oe_n     = s_nxt.hold_gnt || (s_nxt.bus_st == ST_IDLE);
    end else begin
      s_nxt.pins.addr_status = {s_nxt.cmd_dma, 3'b000};
      s_nxt.pins.ad_out      = s_nxt.wdata;
      s_nxt.pins.ad_oe_n     = s_nxt.hold_gnt || !s_nxt.cmd_write;
    end
    // compatible mode: always high; enhanced: low through a refresh cycle
    s_nxt.pins.refresh = !(s_nxt.enhanced && s_nxt.cmd_refresh && in_cycle(s_nxt.bus_st));
  end

  // state register; reset floats every bus pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign prdata                                  = s_r.prdata;
  assign pready                                  = 1'b1;
  assign pslverr                                 = psel && penable && s_r.perr;
  assign processor_clock_output                  = s_r.clk_div;
  assign bus_pins                                = s_r.pins;
  assign hold_granted                            = s_r.hold_gnt;
  assign interrupt_request_two_or_ack_zero_out   = s_r.ack_n[0];
  assign interrupt_request_two_or_ack_zero_oe_n  = !s_r.ack_mode[0];
  assign interrupt_request_three_or_ack_one_out  = s_r.ack_n[1];
  assign interrupt_request_three_or_ack_one_oe_n = !s_r.ack_mode[1];
  assign dma_request_sync                        = s_r.dma_s2;
  assign interrupt_pending                       = s_r.int_pend;
  assign nmi_take                                = s_r.nmi_take;
  assign nmi_vector                              = NMI_VECTOR_TYPE;
  assign enhanced_mode                           = s_r.enhanced;

endmodule : cpu_bus_pin_front_end

// file: tb/cpu_bus_pin_front_end_assertions.sv
// concurrent checks on the ports of the local bus pin front end
module cpu_bus_pin_front_end_assertions (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire cpu_bus_pkg::bus_pins_t bus_pins,
  input wire logic                   hold_granted,
  input wire logic                   enhanced_mode,
  input wire logic                   nmi_input,
  input wire logic                   instruction_boundary,
  input wire logic                   nmi_take,
  input wire logic [7:0]             nmi_vector,
  input wire logic                   dma_request_channel_zero,
  input wire logic [1:0]             dma_request_sync,
  input wire logic                   interrupt_request_two_or_ack_zero_out,
  input wire logic                   interrupt_request_two_or_ack_zero_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_bus_pkg::*;
  // all checks sample on the bus clock; all but a_reset_float rest while reset is held
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // this one watches reset itself, so it is never disabled
  a_reset_float: assert property (disable iff (1'b0) !presetn |->
    bus_pins.addr_oe_n && bus_pins.ad_oe_n && bus_pins.refresh_oe_n) else $error("pins driven in reset");
  a_hold_float: assert property (hold_granted && $past(hold_granted) |->
    bus_pins.addr_oe_n && bus_pins.ad_oe_n && bus_pins.refresh_oe_n) else $error("pins driven in hold");
  a_compat_refresh: assert property (!enhanced_mode && !bus_pins.refresh_oe_n |-> bus_pins.refresh)
    else $error("refresh low in compatible mode");
  // a cycle starts where the low byte starts to be driven
  a_status_low: assert property ($fell(bus_pins.ad_oe_n) && !bus_pins.addr_oe_n |->
    ##2 (bus_pins.addr_status[2:0] == 3'b000) [*6]) else $error("status bits not low");
  a_mid_stable: assert property ($fell(bus_pins.ad_oe_n) && !bus_pins.addr_oe_n |=>
    $stable(bus_pins.addr_mid) [*7]) else $error("middle address moved in cycle");
  a_dma_sync: assert property (dma_request_channel_zero [*4] |-> dma_request_sync[0])
    else $error("dma request not passed");
  a_nmi_vector: assert property (nmi_take |-> nmi_vector == NMI_VECTOR_TYPE)
    else $error("wrong nmi vector");
  a_nmi_boundary: assert property (nmi_take |-> $past(instruction_boundary))
    else $error("nmi taken off boundary");
  a_nmi_latency: assert property ($rose(nmi_input) && instruction_boundary |-> ##[2:6] nmi_take)
    else $error("nmi not taken in time");
  a_ack_pulse: assert property (!interrupt_request_two_or_ack_zero_oe_n &&
    $fell(interrupt_request_two_or_ack_zero_out) |=> interrupt_request_two_or_ack_zero_out)
    else $error("ack pulse too long");
endmodule : cpu_bus_pin_front_end_assertions

// file: tb/cpu_bus_partner_model.sv
// memory and i/o device model answering local bus cycles
module cpu_bus_partner_model (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   processor_clock_output,
  input  wire cpu_bus_pkg::bus_pins_t bus_pins,
  input  wire logic [7:0]             read_byte,
  input  wire logic [3:0]             wait_ticks,
  output logic [7:0]                  ad_in,
  output logic                        bus_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_bus_pkg::*;
  logic       prev_oe_n; // low byte enable one edge ago
  logic [4:0] ticks;     // clock output periods since first state, saturates idle
  // restart the count where the low byte starts to be driven
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_oe_n <= 1'b1;
      ticks     <= 5'h1f;
    end else begin
      prev_oe_n <= bus_pins.ad_oe_n;
      if (prev_oe_n && !bus_pins.ad_oe_n) begin
        ticks <= 5'h00;
      end else if (processor_clock_output && ticks != 5'h1f) begin
        ticks <= ticks + 5'h01;
      end
    end
  end
  // a slow device keeps ready low for wait_ticks periods of the third state
  assign bus_ready = (ticks >= {1'b0, wait_ticks} + 5'h02);
  // read byte only up to the end of the fourth state, inverse once released
  assign ad_in = (bus_pins.ad_oe_n && ticks <= {1'b0, wait_ticks} + 5'h03) ? read_byte : ~read_byte;
endmodule : cpu_bus_partner_model

// file: tb/cpu_bus_pin_front_end_bench.sv
// self-checking bench for the local bus pin front end
module cpu_bus_pin_front_end_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_bus_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, rd_byte = 8'h3c, ad_in, ad_wire, nmi_vec;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        hold_request = 1'b0, mode_strap = 1'b0, boundary = 1'b0, nmi = 1'b0;
  logic        dma0 = 1'b0, dma1 = 1'b0, req0 = 1'b0, req1 = 1'b0, req2 = 1'b0, req3 = 1'b0;
  logic        pready, pslverr, pclk_div, rdy, hold_granted, nmi_take, enh, a0_out, a0_oe_n, a1_out, a1_oe_n;
  logic [1:0]  dma_sync;
  logic [3:0]  int_pend, waits = 4'h0;
  bus_pins_t   bus_pins, t1_pins, t2_pins;
  logic        prev_oe_n = 1'b1, saw_refresh_indicator = 1'b0, saw_ack = 1'b0;
  int          ad_len = 0, fail_count = 0, n_tests = 0;
  // 200 MHz clock
  always #2.5 pclk = ~pclk;
  // low byte pin level from whoever drives it
  assign ad_wire = bus_pins.ad_oe_n ? ad_in : bus_pins.ad_out;
  cpu_bus_pin_front_end dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .processor_clock_output(pclk_div), .bus_pins(bus_pins), .multiplexed_addr_data_low_byte_in(ad_wire),
    .bus_ready(rdy), .hold_request(hold_request), .hold_granted(hold_granted), .mode_strap(mode_strap),
    .dma_request_channel_zero(dma0), .dma_request_channel_one(dma1), .nmi_input(nmi),
    .interrupt_request_zero(req0), .interrupt_request_one(req1),
    .interrupt_request_two_or_ack_zero_in(a0_oe_n ? req2 : a0_out),
    .interrupt_request_two_or_ack_zero_out(a0_out), .interrupt_request_two_or_ack_zero_oe_n(a0_oe_n),
    .interrupt_request_three_or_ack_one_in(a1_oe_n ? req3 : a1_out),
    .interrupt_request_three_or_ack_one_out(a1_out), .interrupt_request_three_or_ack_one_oe_n(a1_oe_n),
    .instruction_boundary(boundary), .dma_request_sync(dma_sync), .interrupt_pending(int_pend),
    .nmi_take(nmi_take), .nmi_vector(nmi_vec), .enhanced_mode(enh));
  cpu_bus_partner_model partner (.pclk(pclk), .presetn(presetn), .processor_clock_output(pclk_div),
    .bus_pins(bus_pins), .read_byte(rd_byte), .wait_ticks(waits), .ad_in(ad_in), .bus_ready(rdy));
  // capture first and second state pins, length of low byte drive, strobes seen
  always @(posedge pclk) begin
    prev_oe_n <= bus_pins.ad_oe_n;
    if (prev_oe_n && !bus_pins.ad_oe_n) begin
      t1_pins <= bus_pins;
      ad_len  <= 1;
    end else if (!bus_pins.ad_oe_n) begin
      ad_len <= ad_len + 1;
    end
    if (ad_len == 2 && !bus_pins.ad_oe_n) t2_pins <= bus_pins;
    if (!bus_pins.refresh_oe_n && bus_pins.refresh === 1'b0) saw_refresh_indicator <= 1'b1;
    if (!a0_oe_n && a0_out === 1'b0) saw_ack <= 1'b1;
  end
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // print counts and verdict, end the run
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // a wait that ran out counts as a mismatch and ends the run
  task automatic gate(input logic ok, input string what);
    if (!ok) begin
      chk(what, 32'h0, 32'h1);
      close_out();
    end
  endtask : gate
  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    gate(pready === 1'b1, "pready wait");
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd
  // start one local bus cycle and poll busy until it ends
  task automatic bus_cycle(input logic [19:0] a, input logic [7:0] d, input logic [3:0] cmd);
    logic [31:0] q;
    int          n;
    wr(OFS_BUS_ADDR, {12'h000, a});
    wr(OFS_BUS_WDATA, {24'h0, d});
    wr(OFS_BUS_CMD, {28'h0, cmd});
    n = 0;
    do begin
      rd(OFS_STATUS, q);
      n++;
    end while (q[8] !== 1'b0 && n < 64);
    gate(q[8] === 1'b0, "busy wait");
  endtask : bus_cycle
  // reset for 16 cycles with the mode strap pattern
  task automatic do_reset(input logic strap);
    presetn    <= 1'b0;
    mode_strap <= strap;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    mode_strap <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask : do_reset
  initial begin
    logic [31:0] q;
    logic        e;
    int          n;
    // registers: reset value, readback, unmapped offset
    do_reset(1'b0);
    chk("enhanced", enh, 32'h0);
    rd(OFS_CONFIG, q);
    chk("config reset", q, {26'h0, ACK_MODE_RST, EDGE_SEL_RST});
    wr(OFS_CONFIG, 32'h12);
    rd(OFS_CONFIG, q);
    chk("config", q, 32'h12);
    apb(1'b0, 8'h1c, 32'h0, q, e);
    chk("slverr", e, 32'h1);
    chk("unmapped", q, 32'h0);
    $display("test registers done");
    // processor write, then dma write with two wait states
    bus_cycle(20'h5a3c7, 8'ha5, 4'h3);
    chk("t1 upper", t1_pins.addr_status, 32'h5);
    chk("t1 low", t1_pins.ad_out, 32'hc7);
    chk("mid", t1_pins.addr_mid, 32'ha3);
    chk("t2 data", t2_pins.ad_out, 32'ha5);
    chk("t2 status", t2_pins.addr_status, 32'h0);
    chk("length", ad_len, 32'd8);
    waits <= 4'h2;
    bus_cycle(20'h81234, 8'h5a, 4'h7);
    chk("dma status", t2_pins.addr_status, 32'h8);
    chk("wait length", ad_len, 32'd12);
    // refresh read in compatible mode
    waits    <= 4'h0;
    saw_refresh_indicator <= 1'b0;
    bus_cycle(20'h0ff01, 8'h00, 4'h9);
    chk("compat refresh", saw_refresh_indicator, 32'h0);
    chk("read length", ad_len, 32'd2);
    rd(OFS_BUS_RDATA, q);
    chk("read byte", q, 32'h3c);
    $display("test bus cycles done");
    // bus hold floats all pins
    hold_request <= 1'b1;
    for (n = 0; n < 64 && hold_granted !== 1'b1; n++) @(posedge pclk);
    gate(hold_granted === 1'b1, "hold wait");
    @(posedge pclk);
    chk("hold float", {bus_pins.addr_oe_n, bus_pins.ad_oe_n, bus_pins.refresh_oe_n}, 32'h7);
    hold_request <= 1'b0;
    for (n = 0; n < 64 && hold_granted !== 1'b0; n++) @(posedge pclk);
    gate(hold_granted === 1'b0, "release wait");
    $display("test hold done");
    // requests: level ones follow their pins, the edge one is held until acknowledged
    dma0 <= 1'b1;
    dma1 <= 1'b1;
    req0 <= 1'b1;
    req1 <= 1'b1;
    req2 <= 1'b1;
    req3 <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(OFS_STATUS, q);
    chk("dma sync", q[1:0], 32'h3);
    chk("pending", q[5:2], 32'hb);
    req0 <= 1'b0;
    req3 <= 1'b0;
    wr(OFS_INT_ACK, 32'h2);
    saw_ack <= 1'b0;
    wr(OFS_INT_ACK, 32'h4);
    repeat (4) @(posedge pclk);
    rd(OFS_STATUS, q);
    chk("pending cleared", q[5:2], 32'h0);
    chk("ack pulse", saw_ack, 32'h1);
    $display("test requests done");
    // nmi with every config bit set, pulse one clock output period
    wr(OFS_CONFIG, 32'h3f);
    nmi <= 1'b1;
    repeat (2) @(posedge pclk);
    nmi <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(OFS_STATUS, q);
    chk("nmi pending", q[6], 32'h1);
    boundary <= 1'b1;
    for (n = 0; n < 16 && nmi_take !== 1'b1; n++) @(posedge pclk);
    gate(nmi_take === 1'b1, "nmi wait");
    chk("vector", nmi_vec, 32'h2);
    nmi <= 1'b1;
    repeat (2) @(posedge pclk);
    nmi <= 1'b0;
    repeat (8) @(posedge pclk);
    $display("test nmi done");
    // enhanced mode marks refresh cycles
    do_reset(1'b1);
    chk("enhanced", enh, 32'h1);
    saw_refresh_indicator <= 1'b0;
    bus_cycle(20'h00010, 8'h00, 4'h9);
    chk("enhanced refresh", saw_refresh_indicator, 32'h1);
    $display("test enhanced done");
    close_out();
  end
endmodule : cpu_bus_pin_front_end_bench
// checker beside the design
bind cpu_bus_pin_front_end cpu_bus_pin_front_end_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .bus_pins(bus_pins), .hold_granted(hold_granted), .enhanced_mode(enhanced_mode), .nmi_input(nmi_input),
  .instruction_boundary(instruction_boundary), .nmi_take(nmi_take), .nmi_vector(nmi_vector),
  .dma_request_channel_zero(dma_request_channel_zero), .dma_request_sync(dma_request_sync),
  .interrupt_request_two_or_ack_zero_out(interrupt_request_two_or_ack_zero_out),
  .interrupt_request_two_or_ack_zero_oe_n(interrupt_request_two_or_ack_zero_oe_n));
